// ---- hw/bcfb_pkg.sv ----
// Purpose: shared constants, types and helpers for the bit-clear and
//          flag-branch execute block
// Assumes: 32-bit register bus, 12-bit data address, 21-bit program counter
// Notes:   one word per register, offsets are byte addresses
package bcfb_pkg;

	// Widths
	localparam int PC_W = 21;
	localparam int DA_W = 12;

	// Register offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_BANK   = 8'h04;
	localparam logic [7:0] OFS_INDEX  = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_PC     = 8'h10;
	localparam logic [7:0] OFS_STATE  = 8'h14;

	// Field positions
	localparam int CTRL_EXT_BIT  = 0;
	localparam int STATUS_C_BIT  = 0;
	localparam int STATUS_N_BIT  = 4;
	localparam int WORD_A_BIT    = 8;
	localparam int WORD_BIT_LSB  = 9;

	// Reset values
	localparam logic             RST_EXT   = 1'b0;
	localparam logic [3:0]       RST_BANK  = 4'h0;
	localparam logic [DA_W-1:0]  RST_INDEX = 12'h000;
	localparam logic             RST_FLAG  = 1'b0;
	localparam logic [PC_W-1:0]  RST_PC    = 21'h000000;

	// Opcodes and address split points
	localparam logic [3:0] OP_CLEAR       = 4'h9;
	localparam logic [7:0] OP_NEG         = 8'he6;
	localparam logic [7:0] OP_NO_CARRY    = 8'he3;
	localparam logic [7:0] OP_NOT_NEG     = 8'he7;
	localparam logic [7:0] IDX_LIMIT      = 8'h5f;
	localparam logic [7:0] ACCESS_SPLIT   = 8'h60;
	localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
	localparam logic [PC_W-1:0] PC_STEP   = 21'h000002;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_EXEC = 2'b01,
		ST_NOP  = 2'b10
	} bcfb_state_type;

	typedef enum logic [1:0] {
		Q1 = 2'b00,
		Q2 = 2'b01,
		Q3 = 2'b10,
		Q4 = 2'b11
	} bcfb_phase_type;

	// Advanced counter plus doubled signed offset
	function automatic logic [PC_W-1:0] bcfb_target(
		input logic [PC_W-1:0] pc_next,
		input logic [7:0]      n);
		return pc_next + {{(PC_W-9){n[7]}}, n, 1'b0};
	endfunction

	// Branch condition per opcode byte; zero for any other byte
	function automatic logic bcfb_take(
		input logic [7:0] op,
		input logic       neg,
		input logic       carry);
		logic t;
		t = 1'b0;
		if (op == OP_NEG)
			t = neg;
		else if (op == OP_NO_CARRY)
			t = ~carry;
		else if (op == OP_NOT_NEG)
			t = ~neg;
		return t;
	endfunction

endpackage

// ---- hw/bcfb_calc_if.sv ----
// Purpose: carries the decoded instruction between core and calculator
// Assumes: one clock domain, purely combinational calculator
// Notes:   core drives the operands, calculator drives the results
`timescale 1ns/1ns
interface bcfb_calc_if;
	import bcfb_pkg::*;
	logic [15:0]     word;
	logic [3:0]      bank_select_register;
	logic            ext_en;
	logic [DA_W-1:0] index_base;
	logic [PC_W-1:0] pc;
	logic            flag_n;
	logic            flag_c;
	logic            is_clear;
	logic            is_branch;
	logic            take;
	logic [DA_W-1:0] file_addr;
	logic [7:0]      bit_mask;
	logic [PC_W-1:0] target;
	modport core (output word, bank_select_register, ext_en, index_base,
		pc, flag_n, flag_c,
		input is_clear, is_branch, take, file_addr, bit_mask, target);
	modport calc (input word, bank_select_register, ext_en, index_base,
		pc, flag_n, flag_c,
		output is_clear, is_branch, take, file_addr, bit_mask, target);
endinterface

// ---- hw/bcfb_calc.sv ----
// Purpose: decode of the held word, data address and branch target
// Assumes: inputs are held steady for the whole instruction cycle
// Notes:   no state; unknown opcodes decode to neither kind
`timescale 1ns/1ns
module bcfb_calc (
	bcfb_calc_if.calc cif
);
	import bcfb_pkg::*;

	wire [7:0] f_field;
	wire       a_bit;
	wire       use_index;
	wire [3:0] access_bank;

	// Opcode classes
	assign cif.is_clear  = (cif.word[15:12] == OP_CLEAR);
	assign cif.is_branch = (cif.word[15:8] == OP_NEG)
		| (cif.word[15:8] == OP_NO_CARRY)
		| (cif.word[15:8] == OP_NOT_NEG);

	// Branch condition from the frozen flags
	assign cif.take = bcfb_take(cif.word[15:8], cif.flag_n,
		cif.flag_c);

	// Target from the already advanced counter
	assign cif.target = bcfb_target(cif.pc, cif.word[7:0]);

	// Address mode select for the file operand
	assign f_field     = cif.word[7:0];
	assign a_bit       = cif.word[WORD_A_BIT];
	assign use_index   = cif.ext_en & (f_field <= IDX_LIMIT);
	assign access_bank = (f_field < ACCESS_SPLIT) ? 4'h0 : ACCESS_HI_BANK;
	assign cif.file_addr = a_bit ? {cif.bank_select_register, f_field}
		: use_index ? DA_W'(cif.index_base + {4'h0, f_field})
		: {access_bank, f_field};

	// One-hot mask of the bit to clear
	assign cif.bit_mask = 8'h01 << cif.word[WORD_BIT_LSB +: 3];

endmodule

// ---- hw/bcfb_top.sv ----
// Purpose: executes bit-clear on a file register and three flag branches
// Assumes: four clocks per instruction cycle, data memory reads
//          asynchronously, fetch and memory share hclk
// Notes:   configuration writes are dropped while an instruction runs
// Notes on behaviour
// - Bit-clear reads the file, zeroes one bit, writes back in Q4.
// - Bank bit clear selects access bank; set selects bank register.
// - Bank bit clear, extended set, file <= 5Fh: indexed offset mode.
// - Branch on negative jumps only when the negative flag is one.
// - Branch on no carry jumps only when the carry flag is zero.
// - Branch on not negative jumps only when negative flag is zero.
// - Offset is signed eight bit, doubled before the add.
// - Taken target is branch address plus two plus doubled offset.
// - Branches take one cycle; taken ones add a second idle cycle.
//
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ns
module bcfb_top (
	input  wire logic                      hclk,
	input  wire logic                      hresetn,
	input  wire logic                      hsel,
	input  wire logic [31:0]               haddr,
	input  wire logic [1:0]                htrans,
	input  wire logic                      hwrite,
	input  wire logic [2:0]                hsize,
	input  wire logic [31:0]               hwdata,
	input  wire logic                      hready,
	output logic                           hreadyout,
	output logic                           hresp,
	output logic      [31:0]               hrdata,
	input  wire logic                      instr_valid,
	input  wire logic [15:0]               instr_word,
	output logic                           instr_ready,
	output logic      [bcfb_pkg::DA_W-1:0] dm_addr,
	output logic                           dm_re,
	input  wire logic [7:0]                dm_rdata,
	output logic                           dm_we,
	output logic      [7:0]                dm_wdata,
	output logic      [bcfb_pkg::PC_W-1:0] pc_out
);
	import bcfb_pkg::*;

	bcfb_state_type  state;
	bcfb_state_type  next_state;
	bcfb_phase_type  phase;
	bcfb_phase_type  next_phase;
	logic            dp_wr;
	logic            rd_pend;
	logic [7:0]      dp_addr;
	logic            ctrl_ext;
	logic [3:0]      bank_select_register;
	logic [DA_W-1:0] index_base;
	logic            flag_n;
	logic            flag_c;
	logic [PC_W-1:0] pc;
	logic [15:0]     cur_word;
	logic [7:0]      rd_data;
	wire             addr_ok;
	wire             wr_cfg;
	wire             acc;
	wire             exec;
	wire             jump;
	wire  [31:0]     rd_mux;
	wire  [2:0]      unused_size;

	bcfb_calc_if cif ();

	bcfb_calc u_calc (
		.cif (cif.calc)
	);

	// Operands for the calculator
	assign cif.word       = cur_word;
	assign cif.bank_select_register = bank_select_register;
	assign cif.ext_en     = ctrl_ext;
	assign cif.index_base = index_base;
	assign cif.pc         = pc;
	assign cif.flag_n     = flag_n;
	assign cif.flag_c     = flag_c;

	// Bus address phase and register writes
	assign addr_ok     = hsel & hready & htrans[1];
	assign unused_size = hsize; // Only whole words are supported
	assign wr_cfg      = dp_wr & (state == ST_IDLE);
	assign hreadyout   = ~rd_pend; // One wait state on reads only
	assign hresp       = 1'b0;

	// Read mux; unmapped offsets read as zero
	assign rd_mux =
		(dp_addr == OFS_CTRL)   ? 32'(ctrl_ext) :
		(dp_addr == OFS_BANK)   ? 32'(bank_select_register) :
		(dp_addr == OFS_INDEX)  ? 32'(index_base) :
		(dp_addr == OFS_STATUS) ? 32'({flag_n, 3'h0, flag_c}) :
		(dp_addr == OFS_PC)     ? 32'(pc) :
		(dp_addr == OFS_STATE)  ? 32'({state, phase}) : 32'h0;

	// Instruction handshake and phase strobes
	assign instr_ready = (state == ST_IDLE) & ~dp_wr;
	assign acc         = instr_valid & instr_ready;
	assign exec        = (state == ST_EXEC);
	assign jump        = exec & (phase == Q4) & cif.is_branch
		& cif.take;
	assign pc_out      = pc;

	// Bus data phase tracking
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr <= 1'b0;
			rd_pend <= 1'b0;
			dp_addr <= 8'h00;
			hrdata <= 32'h0;
		end else begin
			dp_wr <= addr_ok & hwrite;
			rd_pend <= addr_ok & ~hwrite;
			if (addr_ok)
				dp_addr <= haddr[7:0];
			if (rd_pend)
				hrdata <= rd_mux;
		end
	end

	// Configuration registers, frozen while busy so the address holds
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_ext <= RST_EXT;
			bank_select_register <= RST_BANK;
			index_base <= RST_INDEX;
		end else if (wr_cfg) begin
			if (dp_addr == OFS_CTRL)
				ctrl_ext <= hwdata[CTRL_EXT_BIT];
			if (dp_addr == OFS_BANK)
				bank_select_register <= hwdata[3:0];
			if (dp_addr == OFS_INDEX)
				index_base <= hwdata[DA_W-1:0];
		end
	end

	// Flags change only by software, never by execution
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag_n <= RST_FLAG;
			flag_c <= RST_FLAG;
		end else if (wr_cfg && dp_addr == OFS_STATUS) begin
			flag_n <= hwdata[STATUS_N_BIT];
			flag_c <= hwdata[STATUS_C_BIT];
		end
	end

	// Counter: load, advance on fetch, or jump in Q4
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			pc <= RST_PC;
		else if (wr_cfg && dp_addr == OFS_PC)
			pc <= hwdata[PC_W-1:0];
		else if (acc)
			pc <= pc + PC_STEP;
		else if (jump)
			pc <= cif.target;
	end

	// Sequencer over the four phases
	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (acc)
					next_state = ST_EXEC;
			end
			ST_EXEC: begin
				if (phase == Q4)
					next_state = jump ? ST_NOP : ST_IDLE;
			end
			ST_NOP: begin
				if (phase == Q4)
					next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	// Phase wraps from Q4 back to Q1
	assign next_phase = (state == ST_IDLE) ? Q1
		: bcfb_phase_type'(phase + 2'b01);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= ST_IDLE;
			phase <= Q1;
		end else begin
			state <= next_state;
			phase <= next_phase;
		end
	end

	// File access: address in Q2, read at Q2 end, write during Q4
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cur_word <= 16'h0000;
			dm_addr <= '0;
			dm_re <= 1'b0;
			rd_data <= 8'h00;
			dm_wdata <= 8'h00;
			dm_we <= 1'b0;
		end else begin
			if (acc)
				cur_word <= instr_word;
			if (exec && phase == Q1)
				dm_addr <= cif.file_addr;
			dm_re <= exec & (phase == Q1) & cif.is_clear;
			if (dm_re)
				rd_data <= dm_rdata;
			if (exec && phase == Q3)
				dm_wdata <= rd_data & ~cif.bit_mask;
			dm_we <= exec & (phase == Q3) & cif.is_clear;
		end
	end

	// Checks on the executed behaviour
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	a_clear_data_ok: assert property (
		dm_we |-> dm_wdata == ($past(dm_rdata, 2) & ~cif.bit_mask))
		else $error("cleared byte does not match read byte");

	a_clear_write_q4: assert property (
		acc && instr_word[15:12] == OP_CLEAR
		|-> !dm_we [*4] ##1 dm_we ##1 !dm_we)
		else $error("bit-clear write not in Q4");

	a_bank_reg_sel: assert property (
		dm_re && cur_word[WORD_A_BIT]
		|-> dm_addr == {bank_select_register, cur_word[7:0]})
		else $error("bank register address wrong");

	a_access_bank_sel: assert property (
		dm_re && !cur_word[WORD_A_BIT]
		&& !(ctrl_ext && cur_word[7:0] <= IDX_LIMIT)
		|-> dm_addr == {(cur_word[7:0] < ACCESS_SPLIT ? 4'h0
		: ACCESS_HI_BANK), cur_word[7:0]})
		else $error("access bank address wrong");

	a_indexed_mode: assert property (
		dm_re && !cur_word[WORD_A_BIT] && ctrl_ext
		&& cur_word[7:0] <= IDX_LIMIT
		|-> dm_addr == index_base + {4'h0, cur_word[7:0]})
		else $error("indexed offset address wrong");

	a_neg_branch: assert property (
		acc && instr_word[15:8] == OP_NEG |-> ##5
		pc == ($past(flag_n, 5) ? bcfb_target($past(pc, 5) + PC_STEP,
		$past(instr_word[7:0], 5)) : $past(pc, 5) + PC_STEP))
		else $error("branch on negative wrong");

	a_no_carry_branch: assert property (
		acc && instr_word[15:8] == OP_NO_CARRY && !flag_c |-> ##5
		pc == bcfb_target($past(pc, 5) + PC_STEP,
		$past(instr_word[7:0], 5)))
		else $error("branch on no carry not taken");

	a_not_neg_branch: assert property (
		acc && instr_word[15:8] == OP_NOT_NEG && flag_n
		|-> ##5 pc == $past(pc, 5) + PC_STEP)
		else $error("branch on not negative taken wrongly");

	a_target_sign: assert property (
		jump && cur_word[7] |=> 21'(pc - $past(pc)) >= 21'h1fff00)
		else $error("negative offset did not go back");

	a_taken_idle: assert property (
		jump |=> (state == ST_NOP) [*4] ##1 state == ST_IDLE)
		else $error("taken branch idle cycle wrong");

	a_untaken_one: assert property (
		acc && !jump ##4 !jump |=> state == ST_IDLE)
		else $error("untaken instruction not one cycle");

	a_flags_hold: assert property (
		state != ST_IDLE |=> $stable({flag_n, flag_c}))
		else $error("flags changed during execution");

	// Phase placement, counter steps and idle work
	a_clear_read_q2: assert property (
		acc && instr_word[15:12] == OP_CLEAR
		|=> !dm_re ##1 dm_re ##1 !dm_re [*3])
		else $error("bit-clear read not in Q2");

	a_clear_bit_zero: assert property (
		dm_we |-> !dm_wdata[cur_word[WORD_BIT_LSB +: 3]])
		else $error("chosen bit not cleared");

	a_pc_advance: assert property (
		acc |=> pc == $past(pc) + PC_STEP)
		else $error("counter did not advance past the word");

	a_even_step: assert property (
		jump |=> pc[0] == $past(pc[0]))
		else $error("jump step is not doubled");

	a_untaken_pc_hold: assert property (
		exec && phase == Q4 && !jump |=> $stable(pc))
		else $error("untaken instruction wrote the counter");

	a_nop_pc_hold: assert property (
		state == ST_NOP |=> $stable(pc))
		else $error("idle cycle changed the counter");

	a_branch_no_mem: assert property (
		exec && cif.is_branch |-> !dm_re && !dm_we)
		else $error("branch touched data memory");

endmodule

// ---- test/bcfb_mem.sv ----
// Purpose: data memory file behind the execute block
// Assumes: asynchronous read of dm_addr, write at the dm_we edge
// Notes:   read lines show inverted contents while dm_re is low
`timescale 1ns/1ns
module bcfb_mem (
	input  wire logic                      hclk,
	input  wire logic [bcfb_pkg::DA_W-1:0] dm_addr,
	input  wire logic                      dm_re,
	input  wire logic                      dm_we,
	input  wire logic [7:0]                dm_wdata,
	output logic      [7:0]                dm_rdata
);
	import bcfb_pkg::*;
	logic [7:0] mem [0:(1<<DA_W)-1];
	// No stale value outside a read strobe, so a late sample is caught
	assign dm_rdata = dm_re ? mem[dm_addr] : ~mem[dm_addr];
	// Write-back lands at the Q4 strobe edge
	always @(posedge hclk) begin
		if (dm_we)
			mem[dm_addr] <= dm_wdata;
	end
endmodule

// ---- test/bit_clear_and_flag_branch_exec_tb.sv ----
// Purpose: random and corner checks of bit-clear and flag branches
// Assumes: one slave on the bus, hready tied to hreadyout
// Notes:   expectations come from local functions only
`timescale 1ns/1ns
module bit_clear_and_flag_branch_exec_tb;
	import bcfb_pkg::*;
	localparam logic [7:0] OPS [3] = '{OP_NEG, OP_NO_CARRY, OP_NOT_NEG};
	logic            hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic            instr_valid, instr_ready, dm_re, dm_we;
	logic            neg, cy, a, ext, t;
	logic [1:0]      htrans;
	logic [2:0]      hsize, b;
	logic [3:0]      bank;
	logic [7:0]      dm_rdata, dm_wdata, off, f, v;
	logic [15:0]     instr_word;
	logic [31:0]     haddr, hwdata, hrdata, rd, st;
	logic [DA_W-1:0] dm_addr, idx, ad;
	logic [PC_W-1:0] pc_out, pc0;
	int              errors, checks;

	bcfb_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .instr_valid(instr_valid),
		.instr_word(instr_word), .instr_ready(instr_ready),
		.dm_addr(dm_addr), .dm_re(dm_re), .dm_rdata(dm_rdata),
		.dm_we(dm_we), .dm_wdata(dm_wdata), .pc_out(pc_out));
	bcfb_mem mem_u (.hclk(hclk), .dm_addr(dm_addr), .dm_re(dm_re),
		.dm_we(dm_we), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata));

	// Free-running bus clock
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end

	// Branch condition per opcode byte, zero for anything else
	function automatic logic taken(input logic [7:0] op, input logic n,
		input logic c);
		return (op == OP_NEG && n) || (op == OP_NO_CARRY && !c)
			|| (op == OP_NOT_NEG && !n);
	endfunction

	// Data address for a bit-clear
	function automatic logic [DA_W-1:0] ea(input logic a_i,
		input logic [7:0] f_i, input logic e, input logic [3:0] bk,
		input logic [DA_W-1:0] ix);
		if (a_i)
			return {bk, f_i};
		if (e && f_i <= 8'h5f)
			return ix + {4'h0, f_i};
		return (f_i < 8'h60) ? {4'h0, f_i} : {4'hf, f_i};
	endfunction

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Sampled mid-cycle, so the edge's own updates never race the check
	task wait_hi(input logic ins, output int n);
		logic ok;
		n = 0;
		ok = 1'b0;
		while (!ok && n < 40) begin
			@(negedge hclk);
			ok = ins ? instr_ready === 1'b1 : hreadyout === 1'b1;
			rd = hrdata;
			@(posedge hclk);
			n++;
		end
		if (!ok) begin
			errors++;
			$display("BAD at %0t: handshake hang", $time);
		end
	endtask

	// One single-word transfer; read data lands in rd
	task bus(input logic w, input logic [7:0] ad_i, input logic [31:0] d);
		int n;
		hsel <= 1'b1;
		haddr <= {24'h0, ad_i};
		htrans <= 2'b10;
		hwrite <= w;
		wait_hi(1'b0, n);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		wait_hi(1'b0, n);
	endtask

	// Offers one word, then times the return of instr_ready
	task exec(input logic [15:0] w, input int cyc,
		input logic [PC_W-1:0] pc_exp);
		int n;
		instr_valid <= 1'b1;
		instr_word <= w;
		wait_hi(1'b1, n);
		instr_valid <= 1'b0;
		instr_word <= ~w;
		wait_hi(1'b1, n);
		chk(32'(n), 32'(cyc));
		chk({11'h0, pc_out}, {11'h0, pc_exp});
	endtask

	task report_and_stop();
		$display("counts: %0d checks, %0d errors", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Whole run is under 1000 cycles; this is far beyond it
	initial begin
		#2000000;
		errors++;
		$display("BAD at %0t: watchdog expired", $time);
		report_and_stop();
	end

	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		instr_valid = 1'b0;
		instr_word = 16'h0;
		errors = 0;
		checks = 0;
		void'($urandom(44001));
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk({11'h0, pc_out}, 32'h0);
		chk({31'h0, hresp}, 32'h0);
		bus(1'b0, OFS_STATE, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0);
		$display("test reset done");
		// First six force each branch taken at the offset extremes
		for (int i = 0; i < 30; i++) begin
			off = (i < 3) ? 8'h80 : (i < 6) ? 8'h7f : 8'($urandom);
			neg = (i < 6) ? (OPS[i%3] != OP_NOT_NEG) : 1'($urandom);
			cy = (i < 6) ? 1'b0 : 1'($urandom);
			pc0 = 21'($urandom) & 21'h1ffffe;
			st = {27'h0, neg, 3'h0, cy};
			t = taken(OPS[i%3], neg, cy);
			bus(1'b1, OFS_STATUS, st);
			bus(1'b1, OFS_PC, {11'h0, pc0});
			exec({OPS[i%3], off}, t ? 9 : 5, pc0 + 21'h2
				+ (t ? {{12{off[7]}}, off, 1'b0} : 21'h0));
			bus(1'b0, OFS_STATUS, 32'h0);
			chk(rd, st);
		end
		$display("test branches done");
		// First eight sit on the indexed-offset boundary
		for (int i = 0; i < 24; i++) begin
			a = (i < 8) ? 1'b0 : 1'($urandom);
			ext = (i < 8) ? i[1] : 1'($urandom);
			f = (i < 8) ? (i[0] ? 8'h5f : 8'h60) : 8'($urandom);
			b = 3'($urandom);
			bank = 4'($urandom);
			idx = 12'($urandom);
			st = {27'h0, 1'($urandom), 3'h0, 1'($urandom)};
			pc0 = 21'($urandom) & 21'h1ffffe;
			ad = ea(a, f, ext, bank, idx);
			v = 8'($urandom) | (8'h1 << b);
			mem_u.mem[ad] = v;
			bus(1'b1, OFS_CTRL, {31'h0, ext});
			bus(1'b1, OFS_BANK, {28'h0, bank});
			bus(1'b1, OFS_INDEX, {20'h0, idx});
			bus(1'b1, OFS_STATUS, st);
			bus(1'b1, OFS_PC, {11'h0, pc0});
			exec({OP_CLEAR, b, a, f}, 5, pc0 + 21'h2);
			chk({24'h0, mem_u.mem[ad]}, {24'h0, v & ~(8'h1 << b)});
			bus(1'b0, OFS_STATUS, 32'h0);
			chk(rd, st);
		end
		$display("test bit clear done");
		// A byte outside the three branches must not jump
		bus(1'b1, OFS_STATUS, 32'h10);
		exec(16'he5aa, 5, pc0 + 21'h4);
		$display("test other opcode done");
		report_and_stop();
	end
endmodule
